/* logic/spdif_in_pkg.sv */
// Shared types and constants of the serial audio input front end
package spdif_in_pkg;

  // ==========================================================
  // Formats and word widths
  typedef enum logic [1:0] {
    FMT_I2S   = 2'b00,
    FMT_LEFT  = 2'b01,
    FMT_RIGHT = 2'b10
  } fmt_t;

  typedef enum logic [1:0] {
    WID_16 = 2'b00,
    WID_18 = 2'b01,
    WID_20 = 2'b10,
    WID_24 = 2'b11
  } wid_t;

  // ==========================================================
  // Frame geometry, delays in bit clocks
  localparam logic [5:0] DLY_I2S   = 6'h01;
  localparam logic [5:0] DLY_LEFT  = 6'h00;
  localparam logic [5:0] DLY_RJ_16 = 6'h10;
  localparam logic [5:0] DLY_RJ_18 = 6'h0E;
  localparam logic [5:0] DLY_RJ_20 = 6'h0C;
  localparam logic [5:0] DLY_RJ_24 = 6'h08;
  localparam logic [5:0] BITS_16   = 6'h10;
  localparam logic [5:0] BITS_18   = 6'h12;
  localparam logic [5:0] BITS_20   = 6'h14;
  localparam logic [5:0] BITS_24   = 6'h18;
  localparam logic [5:0] CNT_MAX   = 6'h3F;
  localparam logic [5:0] RJ_LAST   = 6'h1F;

  // ==========================================================
  // Oversampling divider: cells per frame and edges per cell
  localparam int         CELLS_PER_FRAME = 128;
  localparam int         OSR_LOW         = 256;
  localparam int         OSR_HIGH        = 384;
  localparam logic [1:0] DIV_LOW         = 2'(OSR_LOW / CELLS_PER_FRAME);
  localparam logic [1:0] DIV_HIGH        = 2'(OSR_HIGH / CELLS_PER_FRAME);

  // ==========================================================
  // Reset and restart values
  localparam logic [5:0]  CNT_RST   = 6'h00;
  localparam logic [23:0] SHIFT_RST = 24'h00_0000;
  localparam logic [1:0]  DIV_RST   = 2'h0;

  typedef struct packed {
    logic        right;
    logic [23:0] data;
  } sample_t;

endpackage : spdif_in_pkg

/* logic/sample_fifo.sv */
// Synchronous FIFO with valid and ready on both sides
module sample_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // Parameter check
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("sample_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      wr_ptr_next;
  logic [AW:0]      rd_ptr_reg;
  logic [AW:0]      rd_ptr_next;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  // ==========================================================
  // Pointers
  always_comb begin
    full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    empty       = (wr_ptr_reg == rd_ptr_reg);
    in_ready    = !full;
    out_valid   = !empty;
    push        = ce && in_valid && !full;
    pop         = ce && out_ready && !empty;
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Storage holds no reset: only slots behind the pointers are ever read
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  assign out_data = mem[rd_ptr_reg[AW-1:0]];

  // The write pointer legally moves on the edge that fills the buffer, so stability is judged one edge on
  chk_fifo_full_stall : assert property (@(posedge mclk) disable iff (!resetn)
    full |-> !in_ready ##1 $stable(wr_ptr_reg))
    else $error("FIFO accepted a word while full");

endmodule : sample_fifo

/* logic/spdif_serial_in.sv */
// Serial audio input front end with oversampling clock divider
// Function
// - Accept left-justified, I2S or right-justified words of 16, 18, 20 or 24 bits.
// - Capture data and frame sync on each rising serial bit clock edge.
// - Right-justified: sync high is left; MSB 16/14/12/8 clocks after transition.
// - I2S, the default: sync low is left; MSB one clock after transition.
// - Left-justified: sync high is left; MSB coincides with the transition.
// - Divide the oversampling clock down into the internal biphase clock.
module spdif_serial_in #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  input  wire logic                  sclk,
  input  wire logic                  fsync,
  input  wire logic                  sdata,
  input  wire logic                  oversampling_clock,
  input  wire spdif_in_pkg::fmt_t    fmt,
  input  wire spdif_in_pkg::wid_t    wid,
  input  wire logic                  osr_384,
  output logic                       sample_valid,
  input  wire logic                  sample_ready,
  output spdif_in_pkg::sample_t      sample,
  output logic                       overrun,
  output logic                       biphase_clk,
  output logic                       biphase_tick
);

  // ==========================================================
  // Parameter check
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
    $error("spdif_serial_in: FIFO_DEPTH must be a power of two of at least 2");
  end

  // ==========================================================
  // Serial capture state
  logic                  sclk_reg;
  logic                  fs_reg;
  logic                  fs_reg_next;
  logic                  synced_reg;
  logic                  synced_next;
  logic                  chan_right_reg;
  logic                  chan_right_next;
  logic [5:0]            cnt_reg;
  logic [5:0]            cnt_next;
  logic [23:0]           shift_reg;
  logic [23:0]           shift_next;
  logic                  overrun_reg;
  logic                  overrun_next;
  logic                  sclk_rise;
  logic                  fs_edge;
  logic [5:0]            idx_now;
  logic [5:0]            dly;
  logic [5:0]            nbits;
  logic [5:0]            last_idx;
  logic                  in_word;
  logic                  word_done;
  logic                  fifo_in_ready;
  spdif_in_pkg::sample_t word;

  always_comb begin
    sclk_rise = ce && sclk && !sclk_reg;
    fs_edge   = sclk_rise && (fsync != fs_reg);
    case (wid)
      spdif_in_pkg::WID_16: nbits = spdif_in_pkg::BITS_16;
      spdif_in_pkg::WID_18: nbits = spdif_in_pkg::BITS_18;
      spdif_in_pkg::WID_20: nbits = spdif_in_pkg::BITS_20;
      default:              nbits = spdif_in_pkg::BITS_24;
    endcase
    case (fmt)
      spdif_in_pkg::FMT_LEFT: dly = spdif_in_pkg::DLY_LEFT;
      spdif_in_pkg::FMT_RIGHT: begin
        case (wid)
          spdif_in_pkg::WID_16: dly = spdif_in_pkg::DLY_RJ_16;
          spdif_in_pkg::WID_18: dly = spdif_in_pkg::DLY_RJ_18;
          spdif_in_pkg::WID_20: dly = spdif_in_pkg::DLY_RJ_20;
          default:              dly = spdif_in_pkg::DLY_RJ_24;
        endcase
      end
      default: dly = spdif_in_pkg::DLY_I2S;
    endcase
    last_idx  = 6'(dly + nbits - 6'h01);
    // Position zero is the edge on which the transition is seen
    idx_now   = fs_edge ? spdif_in_pkg::CNT_RST :
                (cnt_reg == spdif_in_pkg::CNT_MAX) ? cnt_reg : 6'(cnt_reg + 6'h01);
    in_word   = sclk_rise && (synced_reg || fs_edge) && (idx_now >= dly) && (idx_now <= last_idx);
    word_done = in_word && (idx_now == last_idx);
  end

  always_comb begin
    fs_reg_next     = sclk_rise ? fsync : fs_reg;
    synced_next     = synced_reg || fs_edge;
    cnt_next        = sclk_rise ? idx_now : cnt_reg;
    chan_right_next = chan_right_reg;
    if (fs_edge) begin
      // Channel decided by the new sync level and the format polarity
      chan_right_next = (fmt == spdif_in_pkg::FMT_I2S) ? fsync : !fsync;
    end
    shift_next = shift_reg;
    if (fs_edge) begin
      shift_next = spdif_in_pkg::SHIFT_RST;
    end
    if (in_word) begin
      shift_next = {shift_next[22:0], sdata};
    end
    // Serial words cannot be paused, so a full FIFO drops the word and flags it
    overrun_next = overrun_reg || (word_done && !fifo_in_ready);
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sclk_reg       <= 1'b0;
      fs_reg         <= 1'b0;
      synced_reg     <= 1'b0;
      chan_right_reg <= 1'b0;
      cnt_reg        <= spdif_in_pkg::CNT_MAX;
      shift_reg      <= spdif_in_pkg::SHIFT_RST;
      overrun_reg    <= 1'b0;
    end else if (ce) begin
      sclk_reg       <= sclk;
      fs_reg         <= fs_reg_next;
      synced_reg     <= synced_next;
      chan_right_reg <= chan_right_next;
      cnt_reg        <= cnt_next;
      shift_reg      <= shift_next;
      overrun_reg    <= overrun_next;
    end
  end

  assign overrun = overrun_reg;

  always_comb begin
    word.right = fs_edge ? chan_right_next : chan_right_reg;
    word.data  = {shift_reg[22:0], sdata};
  end

  // ==========================================================
  // Output buffer
  sample_fifo #(
    .WIDTH ($bits(spdif_in_pkg::sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .ce        (ce),
    .in_valid  (word_done),
    .in_ready  (fifo_in_ready),
    .in_data   (word),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .out_data  (sample)
  );

  // ==========================================================
  // Oversampling clock divider
  logic       os_reg;
  logic       os_rise;
  logic [1:0] div_reg;
  logic [1:0] div_next;
  logic [1:0] div_len;
  logic       bp_clk_reg;
  logic       bp_clk_next;
  logic       bp_tick_reg;
  logic       bp_tick_next;

  always_comb begin
    os_rise      = ce && oversampling_clock && !os_reg;
    div_len      = osr_384 ? spdif_in_pkg::DIV_HIGH : spdif_in_pkg::DIV_LOW;
    div_next     = div_reg;
    bp_tick_next = 1'b0;
    bp_clk_next  = bp_clk_reg;
    if (os_rise) begin
      if (div_reg == 2'(div_len - 2'h1)) begin
        div_next     = spdif_in_pkg::DIV_RST;
        bp_tick_next = 1'b1;
        bp_clk_next  = !bp_clk_reg;
      end else begin
        div_next = 2'(div_reg + 2'h1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      os_reg      <= 1'b0;
      div_reg     <= spdif_in_pkg::DIV_RST;
      bp_clk_reg  <= 1'b0;
      bp_tick_reg <= 1'b0;
    end else if (ce) begin
      os_reg      <= oversampling_clock;
      div_reg     <= div_next;
      bp_clk_reg  <= bp_clk_next;
      bp_tick_reg <= bp_tick_next;
    end
  end

  assign biphase_clk  = bp_clk_reg;
  assign biphase_tick = bp_tick_reg;

  // ==========================================================
  // Checks
  chk_sync_sample_edge : assert property (@(posedge mclk) disable iff (!resetn)
    sclk_rise |=> fs_reg == $past(fsync))
    else $error("Frame sync not taken on bit clock rise");

  chk_count_restart : assert property (@(posedge mclk) disable iff (!resetn)
    fs_edge |=> cnt_reg == 6'h00 && synced_reg)
    else $error("Bit position not restarted on sync transition");

  chk_rj_last_bit : assert property (@(posedge mclk) disable iff (!resetn)
    word_done && fmt == spdif_in_pkg::FMT_RIGHT |-> idx_now == spdif_in_pkg::RJ_LAST)
    else $error("Right-justified word does not end at position 31");

  chk_i2s_msb : assert property (@(posedge mclk) disable iff (!resetn)
    in_word && fmt == spdif_in_pkg::FMT_I2S |-> idx_now >= 6'h01 && !fs_edge)
    else $error("I2S MSB taken without one clock delay");

  chk_i2s_channel : assert property (@(posedge mclk) disable iff (!resetn)
    fs_edge && fmt == spdif_in_pkg::FMT_I2S |=> chan_right_reg == $past(fsync))
    else $error("I2S channel polarity wrong");

  chk_lj_first : assert property (@(posedge mclk) disable iff (!resetn)
    fs_edge && fmt == spdif_in_pkg::FMT_LEFT |-> in_word ##1 chan_right_reg == !$past(fsync))
    else $error("Left-justified MSB or channel wrong");

  chk_width_len : assert property (@(posedge mclk) disable iff (!resetn)
    word_done && fmt == spdif_in_pkg::FMT_LEFT && wid == spdif_in_pkg::WID_18 |-> idx_now == 6'h11)
    else $error("18-bit word length wrong");

  chk_tick_spacing : assert property (@(posedge mclk) disable iff (!resetn)
    bp_tick_reg |-> div_reg == 2'h0 ##1 !bp_tick_reg)
    else $error("Biphase tick not a single pulse after divider wrap");

  cov_i2s_word   : cover property (@(posedge mclk) disable iff (!resetn) word_done && fmt == spdif_in_pkg::FMT_I2S);
  cov_rj24_word  : cover property (@(posedge mclk) disable iff (!resetn)
    word_done && fmt == spdif_in_pkg::FMT_RIGHT && wid == spdif_in_pkg::WID_24);
  cov_overrun    : cover property (@(posedge mclk) disable iff (!resetn) $rose(overrun_reg));
  cov_tick_384   : cover property (@(posedge mclk) disable iff (!resetn) bp_tick_reg && osr_384);

endmodule : spdif_serial_in

/* tb/audio_source.sv */
// Behavioural serial audio source and oversampling clock feeding the input front end
module audio_source (
  input  wire logic mclk,
  output logic      sclk,
  output logic      fsync,
  output logic      sdata,
  output logic      oversampling_clock
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Idle levels: bit clock stands low between frames
  initial begin
    sclk               = 1'b0;
    fsync              = 1'b0;
    sdata              = 1'b0;
    oversampling_clock = 1'b0;
  end

  // One bit period of 4 mclk; sync and data change only while the clock is low
  task automatic bit_slot(input logic fs, input logic drive, input logic d);
    @(posedge mclk) #1;
    sclk  = 1'b0;
    fsync = fs;
    sdata = drive ? d : ~sdata; // Unused slots toggle so a stale bit never looks valid
    repeat (2) @(posedge mclk);
    #1 sclk = 1'b1;
    @(posedge mclk);
  endtask : bit_slot

  // Half frame of 32 bit clocks: rise 0 carries the sync change, MSB at position dly
  task automatic half(input logic fs, input int dly, input int nb, input logic [23:0] w);
    logic b;
    for (int p = 0; p < 32; p++) begin
      b = (p >= dly && p < dly + nb) ? w[nb - 1 - p + dly] : 1'b0;
      bit_slot(fs, p >= dly && p < dly + nb, b);
    end
  endtask : half

  // ==========================================================
  // Frames
  task automatic send_frame(input spdif_in_pkg::fmt_t f, input int nb, input logic [23:0] l,
                            input logic [23:0] r);
    logic lv;
    int   dly;
    lv  = (f != spdif_in_pkg::FMT_I2S);
    dly = (f == spdif_in_pkg::FMT_I2S) ? 1 : (f == spdif_in_pkg::FMT_LEFT) ? 0 : 32 - nb;
    half(lv, dly, nb, l);
    half(~lv, dly, nb, r);
    @(posedge mclk) #1 sclk = 1'b0;
  endtask : send_frame

  // Dummy right half so the next frame opens with a real sync transition
  task automatic preamble(input spdif_in_pkg::fmt_t f);
    half(f == spdif_in_pkg::FMT_I2S, 32, 0, 24'h00_0000);
    @(posedge mclk) #1 sclk = 1'b0;
  endtask : preamble

  // Oversampling clock: only edge counts matter here, the frame ratio is the caller's part
  task automatic osc_rises(input int n);
    repeat (n) begin
      @(posedge mclk) #1 oversampling_clock = 1'b1;
      @(posedge mclk) #1 oversampling_clock = 1'b0;
    end
  endtask : osc_rises

endmodule : audio_source

/* tb/tb_spdif_serial_in.sv */
// Self-checking bench of the serial audio input front end
module tb_spdif_serial_in;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  mclk, resetn, ce, osr_384, sample_ready;
  logic                  sclk, fsync, sdata, oversampling_clock;
  spdif_in_pkg::fmt_t    fmt;
  spdif_in_pkg::wid_t    wid;
  logic                  sample_valid, overrun, biphase_clk, biphase_tick;
  spdif_in_pkg::sample_t sample;
  int                    failures;
  int                    n_compared;

  audio_source src (.mclk(mclk), .sclk(sclk), .fsync(fsync), .sdata(sdata),
                    .oversampling_clock(oversampling_clock));

  spdif_serial_in #(.FIFO_DEPTH(8)) dut_u (
    .mclk(mclk), .resetn(resetn), .ce(ce), .sclk(sclk), .fsync(fsync), .sdata(sdata),
    .oversampling_clock(oversampling_clock), .fmt(fmt), .wid(wid), .osr_384(osr_384),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample(sample),
    .overrun(overrun), .biphase_clk(biphase_clk), .biphase_tick(biphase_tick));

  // ==========================================================
  // Common tasks
  task automatic check(input string what, input logic [24:0] seen, input logic [24:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out;
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic pulse_reset;
    resetn = 1'b0;
    repeat (5) @(posedge mclk);
    #1 resetn = 1'b1;
  endtask : pulse_reset

  // Pop one word; the wait is bounded so a lost word cannot hang the run
  task automatic pop(output logic [24:0] w);
    int k;
    k = 0;
    // One edge first, so back-to-back pops never lower and raise ready in one time step
    @(posedge mclk) #1;
    while (sample_valid !== 1'b1 && k < 20) begin
      @(posedge mclk) #1;
      k++;
    end
    if (sample_valid !== 1'b1) begin
      failures++;
      close_out();
    end else begin
      w = sample;
      sample_ready = 1'b1;
      @(posedge mclk) #1 sample_ready = 1'b0;
    end
  endtask : pop

  // Discard whatever a preamble left behind, then the buffer must read empty
  task automatic drain;
    repeat (4) @(posedge mclk);
    #1 sample_ready = 1'b1;
    @(posedge mclk) #1;
    for (int i = 0; i < 10 && sample_valid === 1'b1; i++) @(posedge mclk) #1;
    sample_ready = 1'b0;
    check("empty after drain", sample_valid, 1'h0);
  endtask : drain

  // ==========================================================
  // Scenarios
  task automatic formats;
    logic [24:0] w;
    logic [23:0] l, r, m;
    int          nb;
    for (int f = 0; f < 3; f++) begin
      for (int k = 0; k < 4; k++) begin
        fmt = spdif_in_pkg::fmt_t'(f);
        wid = spdif_in_pkg::wid_t'(k);
        nb  = (k == 3) ? 24 : 16 + 2 * k;
        m   = 24'hFF_FFFF >> (24 - nb);
        l   = 24'h9B_5E37 ^ 24'(k);
        r   = 24'hE6_A1C8 ^ 24'(f);
        src.preamble(fmt);
        drain();
        src.send_frame(fmt, nb, l, r);
        pop(w);
        check("left word", w, {1'b0, l & m});
        pop(w);
        check("right word", w, {1'b1, r & m});
      end
    end
  endtask : formats

  // Ten words into eight places with the reader stalled: last two dropped, order kept
  task automatic overrun_fill;
    logic [24:0] w;
    fmt = spdif_in_pkg::FMT_I2S;
    wid = spdif_in_pkg::WID_24;
    src.preamble(fmt);
    drain();
    check("overrun idle", overrun, 1'h0);
    for (int i = 0; i < 5; i++) src.send_frame(fmt, 24, 24'h10_0000 + 24'(i), 24'hF0_0000 - 24'(i));
    repeat (3) @(posedge mclk) #1;
    check("overrun set", overrun, 1'h1);
    for (int i = 0; i < 4; i++) begin
      pop(w);
      check("fifo left", w, {1'b0, 24'h10_0000 + 24'(i)});
      pop(w);
      check("fifo right", w, {1'b1, 24'hF0_0000 - 24'(i)});
    end
    check("empty after fill", sample_valid, 1'h0);
    check("overrun sticky", overrun, 1'h1);
    pulse_reset();
    check("overrun cleared", overrun, 1'h0);
  endtask : overrun_fill

  task automatic divider;
    int   ticks, flips;
    logic last;
    for (int s = 0; s < 3; s++) begin
      osr_384 = (s == 1);
      ce      = (s != 2);
      pulse_reset();
      ticks = 0;
      flips = 0;
      last  = biphase_clk;
      fork
        src.osc_rises(12);
        for (int c = 0; c < 30; c++) begin
          @(negedge mclk);
          ticks += (biphase_tick === 1'b1);
          flips += (biphase_clk !== last);
          last  = biphase_clk;
        end
      join
      // Held clock enable must freeze the divider completely
      check("tick count", 25'(ticks), (s == 2) ? 25'h0 : 25'(12 / ((osr_384 ? 384 : 256) / 128)));
      check("clock toggles", 25'(flips), 25'(ticks));
    end
    ce = 1'b1;
  endtask : divider

  // ==========================================================
  // Clock and main sequence
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    failures     = 0;
    n_compared   = 0;
    ce           = 1'b1;
    osr_384      = 1'b0;
    sample_ready = 1'b0;
    fmt          = spdif_in_pkg::FMT_I2S;
    wid          = spdif_in_pkg::WID_16;
    pulse_reset();
    check("valid at reset", sample_valid, 1'h0);
    check("biphase at reset", biphase_clk, 1'h0);
    formats();
    overrun_fill();
    divider();
    close_out();
  end

endmodule : tb_spdif_serial_in
